/* hw/phy_irq_pkg.sv */
package phy_irq_pkg;

  // Management register addressing.
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] REG_BASIC_STATUS = 5'h01;
  localparam logic [ADDR_W-1:0] REG_ANEG_EXPANSION = 5'h06;
  localparam logic [ADDR_W-1:0] REG_MODE_CONTROL = 5'h11;
  localparam logic [ADDR_W-1:0] REG_INTERRUPT_SOURCE_FLAGS = 5'h1d;
  localparam logic [ADDR_W-1:0] REG_INTERRUPT_MASK = 5'h1e;

  // Field layout: eight sources occupy bits 8..1 of the flag and mask registers.
  localparam int NUM_SOURCES = 8;
  localparam int SOURCE_LSB = 1;
  localparam int SCHEME_SELECT_BIT = 6;
  localparam int ENERGY_DETECT_BIT = 1;

  // Source index within the 8-bit vectors (register bit minus one).
  localparam int SRC_WAKE = 7;
  localparam int SRC_ENERGY = 6;
  localparam int SRC_ANEG_DONE = 5;
  localparam int SRC_REMOTE_FAULT = 4;
  localparam int SRC_LINK_DOWN = 3;
  localparam int SRC_LP_ACK = 2;
  localparam int SRC_PAR_DET_FAULT = 1;
  localparam int SRC_PAGE_RX = 0;

  // Reset values.
  localparam logic [NUM_SOURCES-1:0] MASK_RESET = 8'h00;
  localparam logic [NUM_SOURCES-1:0] FLAGS_RESET = 8'h40;
  localparam logic SCHEME_RESET = 1'b0;
  localparam logic ENERGY_PREV_RESET = 1'b1;
  localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;

  // Energy detect replay timing.
  localparam longint CLK_HZ = 125000000;
  localparam longint REPLAY_DELAY_MS = 1000;
  localparam longint REPLAY_PULSE_MS = 256;
  localparam longint REPLAY_DELAY_CYCLES = (REPLAY_DELAY_MS * CLK_HZ) / 1000;
  localparam longint REPLAY_PULSE_CYCLES = (REPLAY_PULSE_MS * CLK_HZ) / 1000;
  localparam int COUNT_W = 32;

  typedef enum logic [1:0] {
    REPLAY_IDLE = 2'b00,
    REPLAY_ARMED = 2'b01,
    REPLAY_DELAY = 2'b10,
    REPLAY_PULSE = 2'b11
  } replay_state_t;

endpackage : phy_irq_pkg

/* hw/energy_replay_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module energy_replay_timer
  import phy_irq_pkg::*;
#(
  parameter logic [COUNT_W-1:0] DELAY_CYCLES = COUNT_W'(REPLAY_DELAY_CYCLES),
  parameter logic [COUNT_W-1:0] PULSE_CYCLES = COUNT_W'(REPLAY_PULSE_CYCLES)
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic arm,
  input wire logic disarm,
  input wire logic energyDetect,
  output logic pulseActive
);

  replay_state_t state;
  replay_state_t next_state;
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] next_count;

  ////////////////////////////////////////////////////////////////////////////
  // Armed when the flag was cleared with energy still present; the delay runs
  // once energy is gone, then the output is held for the pulse length.
  // Clearing the mask abandons the sequence at any point, which is why
  // software should keep the mask set while servicing this source.
  always_comb
  begin
    next_state = state;
    next_count = count;
    unique case (state)
      REPLAY_IDLE:
      begin
        if (arm)
          next_state = REPLAY_ARMED;
      end
      REPLAY_ARMED:
      begin
        next_count = '0;
        if (disarm)
          next_state = REPLAY_IDLE;
        else if (!energyDetect)
          next_state = REPLAY_DELAY;
      end
      REPLAY_DELAY:
      begin
        next_count = count + 1'b1;
        if (disarm)
          next_state = REPLAY_IDLE;
        else if (energyDetect)
          next_state = REPLAY_ARMED;
        else if (count == DELAY_CYCLES - 1'b1)
        begin
          next_state = REPLAY_PULSE;
          next_count = '0;
        end
      end
      REPLAY_PULSE:
      begin
        next_count = count + 1'b1;
        if (disarm || count == PULSE_CYCLES - 1'b1)
          next_state = REPLAY_IDLE;
      end
    endcase
  end

  // State registers.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= REPLAY_IDLE;
      count <= '0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign pulseActive = (state == REPLAY_PULSE);

endmodule : energy_replay_timer

`default_nettype wire

/* hw/phy_interrupt_manager.sv */
`timescale 1ns/1ps
`default_nettype none

module phy_interrupt_manager
  import phy_irq_pkg::*;
#(
  parameter logic [COUNT_W-1:0] REPLAY_DELAY = COUNT_W'(REPLAY_DELAY_CYCLES),
  parameter logic [COUNT_W-1:0] REPLAY_PULSE = COUNT_W'(REPLAY_PULSE_CYCLES)
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [DATA_W-1:0] regWriteData,
  output logic [DATA_W-1:0] regReadData,
  input wire logic [3:0] wakeStatus,
  input wire logic energyDetect,
  input wire logic anegComplete,
  input wire logic remoteFault,
  input wire logic linkStatus,
  input wire logic lpAcknowledge,
  input wire logic parallelDetectFault,
  input wire logic pageReceived,
  input wire logic anegRestart,
  output logic interruptSchemeSelect,
  output logic irqOutLow
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic risingEdge(input logic cur, input logic prev);
    risingEdge = cur & ~prev;
  endfunction : risingEdge

  function automatic logic fallingEdge(input logic cur, input logic prev);
    fallingEdge = ~cur & prev;
  endfunction : fallingEdge

  function automatic logic regHit(input logic strobe, input logic [ADDR_W-1:0] addr,
                                  input logic [ADDR_W-1:0] target);
    regHit = strobe && (addr == target);
  endfunction : regHit

  ////////////////////////////////////////////////////////////////////////////
  // State.

  logic [NUM_SOURCES-1:0] mask;
  logic [NUM_SOURCES-1:0] flags;
  logic [NUM_SOURCES-1:0] level;
  logic [NUM_SOURCES-1:0] levelPrev;
  logic [NUM_SOURCES-1:0] next_mask;
  logic [NUM_SOURCES-1:0] next_flags;
  logic [NUM_SOURCES-1:0] assertEvent;
  logic [NUM_SOURCES-1:0] primaryClear;
  logic [NUM_SOURCES-1:0] altIdle;
  logic [NUM_SOURCES-1:0] writeOnes;
  logic next_scheme;
  logic next_irqOutLow;
  logic [DATA_W-1:0] next_regReadData;
  logic readFlags;
  logic readStatus;
  logic readExpansion;
  logic linkDownEvent;
  logic replayArm;
  logic replayActive;

  // Source levels in register bit order; link down is active while link is low.
  // The wake source is the OR of its four status bits.
  assign level = {|wakeStatus, energyDetect, anegComplete, remoteFault,
                  ~linkStatus, lpAcknowledge, parallelDetectFault, pageReceived};

  assign readFlags = regHit(regRead, regAddr, REG_INTERRUPT_SOURCE_FLAGS);
  assign readStatus = regHit(regRead, regAddr, REG_BASIC_STATUS);
  assign readExpansion = regHit(regRead, regAddr, REG_ANEG_EXPANSION);
  assign linkDownEvent = fallingEdge(linkStatus, ~levelPrev[SRC_LINK_DOWN]);
  assign writeOnes = regWriteData[SOURCE_LSB +: NUM_SOURCES];

  ////////////////////////////////////////////////////////////////////////////
  // Event and clear terms, all sampled on the device clock.
  always_comb
  begin
    for (int i = 0; i < NUM_SOURCES; i++)
    begin
      assertEvent[i] = risingEdge(level[i], levelPrev[i]) & mask[i];
      primaryClear[i] = fallingEdge(level[i], levelPrev[i]) | readFlags;
      altIdle[i] = ~level[i];
    end
    // Link down has no edge-based clear; in the primary scheme only reads release it.
    primaryClear[SRC_LINK_DOWN] = readFlags | readStatus;
    primaryClear[SRC_REMOTE_FAULT] = primaryClear[SRC_REMOTE_FAULT] | readStatus;
    // Wake deasserts on level, not edge: all four bits low.
    primaryClear[SRC_WAKE] = ~level[SRC_WAKE] | readFlags;
    for (int i = SRC_PAGE_RX; i <= SRC_PAR_DET_FAULT; i++)
      primaryClear[i] = primaryClear[i] | readExpansion | anegRestart | linkDownEvent;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register and flag next values. A new event wins over any clear in the
  // same cycle so no interrupt is lost to a racing read or write.
  always_comb
  begin
    next_mask = mask;
    next_scheme = interruptSchemeSelect;
    next_flags = flags;
    if (regHit(regWrite, regAddr, REG_INTERRUPT_MASK))
      next_mask = writeOnes;
    if (regHit(regWrite, regAddr, REG_MODE_CONTROL))
      next_scheme = regWriteData[SCHEME_SELECT_BIT];
    if (!interruptSchemeSelect)
      next_flags = flags & ~primaryClear;
    else if (regHit(regWrite, regAddr, REG_INTERRUPT_SOURCE_FLAGS))
      next_flags = flags & ~(writeOnes & altIdle);
    next_flags = next_flags | assertEvent;
  end

  // Arm the energy replay when its flag drops while energy is still present.
  assign replayArm = mask[SRC_ENERGY] & flags[SRC_ENERGY] & ~next_flags[SRC_ENERGY]
                     & energyDetect;

  energy_replay_timer #(
    .DELAY_CYCLES(REPLAY_DELAY),
    .PULSE_CYCLES(REPLAY_PULSE)
  ) u_energy_replay_timer (
    .clk(clk),
    .rst_b(rst_b),
    .arm(replayArm),
    .disarm(~mask[SRC_ENERGY]),
    .energyDetect(energyDetect),
    .pulseActive(replayActive)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Output and read data. Masking is applied at the output so that clearing a
  // mask bit drops the interrupt at once in either scheme.
  always_comb
  begin
    // The replay pulse also answers to the energy mask, so dropping that mask
    // silences a pulse already under way in the same cycle.
    next_irqOutLow = ~(|(next_flags & next_mask) | (replayActive & next_mask[SRC_ENERGY]));
    next_regReadData = READ_ZERO;
    if (regRead)
    begin
      unique case (regAddr)
        REG_INTERRUPT_SOURCE_FLAGS: next_regReadData[SOURCE_LSB +: NUM_SOURCES] = flags;
        REG_INTERRUPT_MASK: next_regReadData[SOURCE_LSB +: NUM_SOURCES] = mask;
        REG_MODE_CONTROL:
        begin
          next_regReadData[SCHEME_SELECT_BIT] = interruptSchemeSelect;
          next_regReadData[ENERGY_DETECT_BIT] = energyDetect;
        end
        default: next_regReadData = READ_ZERO;
      endcase
    end
    else
      next_regReadData = regReadData;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers: the mask bits and the scheme select. Both come up in
  // the primary, fully masked state so nothing fires before software is ready.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mask <= MASK_RESET;
      interruptSchemeSelect <= SCHEME_RESET;
    end
    else
    begin
      mask <= next_mask;
      interruptSchemeSelect <= next_scheme;
    end
  end

  // Flags and source history. Energy detect powers up as present, so its
  // history and flag start high and fall away if no signal turns up.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      flags <= FLAGS_RESET;
      levelPrev <= FLAGS_RESET;
    end
    else
    begin
      flags <= next_flags;
      levelPrev <= level;
    end
  end

  // Output and read data registers. The interrupt idles high during reset,
  // and the read data holds its last value between reads.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irqOutLow <= 1'b1;
      regReadData <= READ_ZERO;
    end
    else
    begin
      irqOutLow <= next_irqOutLow;
      regReadData <= next_regReadData;
    end
  end

endmodule : phy_interrupt_manager

`default_nettype wire

/* tb/irq_port_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_port_monitor
  import phy_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [DATA_W-1:0] regWriteData,
  input wire logic [DATA_W-1:0] regReadData,
  input wire logic energyDetect,
  input wire logic interruptSchemeSelect,
  input wire logic irqOutLow
);
  // One clock domain, so reset masks every check at once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic mapped;
  logic isMode;
  // Only three registers read back; the rest must read as zero.
  assign isMode = regAddr == REG_MODE_CONTROL;
  assign mapped = isMode || regAddr == REG_INTERRUPT_SOURCE_FLAGS || regAddr == REG_INTERRUPT_MASK;
  ////////////////////////////////////////////////////////////////
  reset_idle_a: assert property ($rose(rst_b) |-> irqOutLow && !interruptSchemeSelect)
    else $error("not idle after reset");
  unmapped_zero_a: assert property (regRead && !mapped |=> regReadData == 16'h0000)
    else $error("unmapped read not zero");
  scheme_cause_a: assert property ($changed(interruptSchemeSelect) |-> $past(regWrite && isMode))
    else $error("scheme changed without write");
  scheme_write_a: assert property (regWrite && isMode |=> interruptSchemeSelect == $past(regWriteData[6]))
    else $error("scheme write lost");
  mode_read_a: assert property (regRead && isMode |=> regReadData[1] == $past(energyDetect))
    else $error("energy readback wrong");
  flag_spare_a: assert property (regRead && regAddr == REG_INTERRUPT_SOURCE_FLAGS
    |=> regReadData[0] == 1'b0 && regReadData[15:9] == 7'h00)
    else $error("spare flag bits set");
  read_hold_a: assert property (!regRead |=> $stable(regReadData))
    else $error("read data moved");
  mask_back_a: assert property (regWrite && regAddr == REG_INTERRUPT_MASK ##2 regRead && regAddr == REG_INTERRUPT_MASK
    |=> regReadData == ($past(regWriteData, 3) & 16'h01fe))
    else $error("mask readback wrong");
  mask_clear_a: assert property (regWrite && regAddr == REG_INTERRUPT_MASK && regWriteData[8:1] == 8'h00
    |=> irqOutLow)
    else $error("irq held after mask clear");
endmodule : irq_port_monitor
`default_nettype wire

/* tb/station_manager.sv */
`timescale 1ns/1ps
`default_nettype none
module station_manager
  import phy_irq_pkg::*;
(
  input wire logic clk,
  output logic [ADDR_W-1:0] regAddr,
  output logic [DATA_W-1:0] regWriteData,
  output logic regRead,
  output logic regWrite
);
  // Idle bus; reads scramble the address and writes scramble the data afterwards so nothing stale matches.
  initial
  begin
    regAddr = 5'h00;
    regWriteData = 16'h0000;
    regRead = 1'b0;
    regWrite = 1'b0;
  end
  // Each access holds its strobe for exactly one taking edge.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    regAddr = a;
    regWriteData = d;
    regWrite = 1'b1;
    @(posedge clk);
    #1;
    regWrite = 1'b0;
    regWriteData = ~d;
  endtask : wr
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    #1;
    regAddr = a;
    regRead = 1'b1;
    @(posedge clk);
    #1;
    regRead = 1'b0;
    regAddr = ~a;
  endtask : rd
endmodule : station_manager
`default_nettype wire

/* tb/test_phy_interrupt_manager.sv */
`timescale 1ns/1ps
`default_nettype none
module test_phy_interrupt_manager
  import phy_irq_pkg::*;
;
  logic clk = 0, rst_b = 0, regRead, regWrite, energyDetect = 1, anegComplete = 0, remoteFault = 0;
  logic linkStatus = 1, lpAcknowledge = 0, parallelDetectFault = 0, pageReceived = 0, anegRestart = 0;
  logic [4:0] regAddr;
  logic [15:0] regWriteData, regReadData;
  logic [3:0] wakeStatus = 4'h0;
  logic interruptSchemeSelect, irqOutLow;
  logic [31:0] seed = 32'h00012c85;
  int errors = 0, samples_checked = 0, cycles = 0;
  always #4 clk = ~clk;
  // Small replay counts keep the cable-removal pulse within reach.
  phy_interrupt_manager #(.REPLAY_DELAY(32'h00000014), .REPLAY_PULSE(32'h00000008)) u_phy_interrupt_manager (
    .clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite),
    .regWriteData(regWriteData), .regReadData(regReadData), .wakeStatus(wakeStatus),
    .energyDetect(energyDetect), .anegComplete(anegComplete), .remoteFault(remoteFault),
    .linkStatus(linkStatus), .lpAcknowledge(lpAcknowledge), .parallelDetectFault(parallelDetectFault),
    .pageReceived(pageReceived), .anegRestart(anegRestart),
    .interruptSchemeSelect(interruptSchemeSelect), .irqOutLow(irqOutLow));
  station_manager u_station_manager (.clk(clk), .regAddr(regAddr), .regWriteData(regWriteData),
    .regRead(regRead), .regWrite(regWrite));
  ////////////////////////////////////////////////////////////////
  // A hang costs a mismatch rather than a silent stall.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      errors++;
      end_of_test();
    end
  end
  function automatic logic [15:0] srcBit(input int i);
    return 16'h0002 << i;
  endfunction : srcBit
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xorshift
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic rdChk(input logic [4:0] a, input logic [15:0] exp);
    u_station_manager.rd(a);
    chk("readback", exp, regReadData);
  endtask : rdChk
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  // Active means the level that raises the source; link down is a falling link.
  task automatic setSrc(input int i, input logic v);
    case (i)
      7: wakeStatus = v ? 4'h1 << xorshift() % 4 : 4'h0;
      6: energyDetect = v;
      5: anegComplete = v;
      4: remoteFault = v;
      3: linkStatus = !v;
      2: lpAcknowledge = v;
      1: parallelDetectFault = v;
      default: pageReceived = v;
    endcase
  endtask : setSrc
  // Raise one masked source, then clear it one way.
  task automatic trial(input int i, input int how);
    u_station_manager.wr(REG_INTERRUPT_MASK, srcBit(i));
    setSrc(i, 1);
    settle();
    chk("irq", 16'h0000, irqOutLow);
    case (how)
      0: setSrc(i, 0);
      1: u_station_manager.rd(REG_BASIC_STATUS);
      2: u_station_manager.rd(REG_ANEG_EXPANSION);
      3: anegRestart = 1;
      default: linkStatus = 0;
    endcase
    @(posedge clk);
    #1;
    anegRestart = 0;
    linkStatus = 1;
    settle();
    chk("irq", 16'h0001, irqOutLow);
    setSrc(i, 0);
  endtask : trial
  task automatic end_of_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1;
    rdChk(REG_INTERRUPT_SOURCE_FLAGS, 16'h0080);
    rdChk(REG_INTERRUPT_MASK, 16'h0000);
    rdChk(REG_MODE_CONTROL, 16'h0002);
    chk("scheme", 16'h0000, interruptSchemeSelect);
    energyDetect = 0;
    repeat (4)
    begin
      void'(xorshift());
      u_station_manager.wr(REG_INTERRUPT_MASK, seed[15:0]);
      rdChk(REG_INTERRUPT_MASK, seed[15:0] & 16'h01fe);
    end
    rdChk(5'h1f, 16'h0000);
    for (int i = 0; i < 8; i++)
    begin
      u_station_manager.wr(REG_INTERRUPT_MASK, srcBit(i));
      setSrc(i, 1);
      settle();
      chk("irq", 16'h0000, irqOutLow);
      rdChk(REG_INTERRUPT_SOURCE_FLAGS, srcBit(i));
      settle();
      chk("irq", 16'h0001, irqOutLow);
      setSrc(i, 0);
      if (i == 6)
      begin
        repeat (24) @(posedge clk);
        #1;
        chk("irq", 16'h0000, irqOutLow);
        repeat (12) @(posedge clk);
        #1;
        chk("irq", 16'h0001, irqOutLow);
      end
    end
    trial(5, 0);
    trial(4, 1);
    trial(3, 1);
    trial(1, 2);
    trial(0, 3);
    trial(1, 4);
    u_station_manager.wr(REG_MODE_CONTROL, 16'h0040);
    rdChk(REG_MODE_CONTROL, 16'h0040);
    chk("scheme", 16'h0001, interruptSchemeSelect);
    u_station_manager.wr(REG_INTERRUPT_MASK, srcBit(4));
    setSrc(4, 1);
    settle();
    u_station_manager.wr(REG_INTERRUPT_SOURCE_FLAGS, srcBit(4));
    settle();
    chk("irq", 16'h0000, irqOutLow);
    rdChk(REG_INTERRUPT_SOURCE_FLAGS, srcBit(4));
    setSrc(4, 0);
    settle();
    chk("irq", 16'h0000, irqOutLow);
    u_station_manager.wr(REG_INTERRUPT_SOURCE_FLAGS, srcBit(4));
    settle();
    chk("irq", 16'h0001, irqOutLow);
    setSrc(4, 1);
    settle();
    u_station_manager.wr(REG_INTERRUPT_MASK, 16'h0000);
    settle();
    chk("irq", 16'h0001, irqOutLow);
    end_of_test();
  end
endmodule : test_phy_interrupt_manager
bind phy_interrupt_manager irq_port_monitor u_irq_port_monitor (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
  .regRead(regRead), .regWrite(regWrite), .regWriteData(regWriteData), .regReadData(regReadData),
  .energyDetect(energyDetect), .interruptSchemeSelect(interruptSchemeSelect), .irqOutLow(irqOutLow));
`default_nettype wire
